// ===== four_level_interrupt_controller.sv
`timescale 1ns/10ps
`include "intc_cfg.svh"
module four_level_interrupt_controller (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // enables and priorities
  input wire logic [7:0] enableRegA,
  input wire logic [7:0] enableRegB,
  input wire logic [7:0] prioLowRegA,
  input wire logic [7:0] prioHighRegA,
  input wire logic [7:0] prioLowRegB,
  input wire logic [7:0] prioHighRegB,
  // external trigger types from timer_ctrl_reg
  input wire logic ext0TriggerType,
  input wire logic ext1TriggerType,
  // external pins, active low
  input wire logic ext0IrqPin_n,
  input wire logic ext1IrqPin_n,
  // peripheral request flags
  input wire logic timer0OverflowFlag,
  input wire logic timer1OverflowFlag,
  input wire logic uartTxFlag,
  input wire logic uartRxFlag,
  input wire logic brownoutFlag,
  input wire logic serialBusAttention,
  input wire logic keypadFlag,
  input wire logic comparator2Flag,
  input wire logic watchdogOverflowFlag,
  input wire logic converterDoneFlag,
  input wire logic comparator1Flag,
  input wire logic busTimeoutFlag,
  // core handshake
  input wire logic vectorAck,
  input wire logic serviceReturn,
  input wire logic powerDown,
  // to core
  output logic irqRequest,
  output logic [15:0] irqVector,
  output logic [1:0] activeLevel,
  output logic serviceActive,
  output logic wakeup,
  output logic ext0RequestFlag,
  output logic ext1RequestFlag
);
  localparam int NS = `INTC_NUM_SRC;
  localparam logic [16*NS-1:0] VECTORS = `VEC_TABLE;
  localparam logic [NS-1:0] WAKE = `WAKE_MASK;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [`INTC_MC_CNT_W-1:0] mcCount;
    logic [3:0] inService;    // bit n set: a routine at level n is running
    logic [15:0] vector;
    logic [3:0] pendSrc;
    logic [1:0] pendLevel;
    logic pend;
  } state_t;

  state_t st;
  state_t next_st;

  logic sampleStrobe;
  logic ext0Ack;
  logic ext1Ack;
  intc_pkg::src_vec_t flags;
  intc_pkg::src_vec_t enables;
  intc_pkg::src_vec_t gated;
  logic [NS-1:0] prioHigh;
  logic [NS-1:0] prioLow;
  logic found;
  logic [3:0] winner;
  logic [1:0] winLevel;
  logic curValid;
  logic [1:0] curLevel;

  // -------------------------------------------------------------------
  // machine cycle strobe
  // -------------------------------------------------------------------
  assign sampleStrobe = (st.mcCount == 3'(`INTC_MC_CLOCKS - 1));

  assign ext0Ack = vectorAck && st.pend && (st.pendSrc == 4'(`SRC_EXT0));
  assign ext1Ack = vectorAck && st.pend && (st.pendSrc == 4'(`SRC_EXT1));

  // -------------------------------------------------------------------
  // external inputs
  // -------------------------------------------------------------------
  ext_irq_input ext0 (
    .clk(clk),
    .rst_n(rst_n),
    .extIrqPin(ext0IrqPin_n),
    .sampleStrobe(sampleStrobe),
    .triggerType(ext0TriggerType),
    .vectorAck(ext0Ack),
    .requestFlag(ext0RequestFlag)
  );

  ext_irq_input ext1 (
    .clk(clk),
    .rst_n(rst_n),
    .extIrqPin(ext1IrqPin_n),
    .sampleStrobe(sampleStrobe),
    .triggerType(ext1TriggerType),
    .vectorAck(ext1Ack),
    .requestFlag(ext1RequestFlag)
  );

  // -------------------------------------------------------------------
  // source gathering
  // -------------------------------------------------------------------
  always_comb begin
    flags = '0;
    flags[`SRC_EXT0] = ext0RequestFlag;
    flags[`SRC_TMR0] = timer0OverflowFlag;
    flags[`SRC_EXT1] = ext1RequestFlag;
    flags[`SRC_TMR1] = timer1OverflowFlag;
    flags[`SRC_UART] = uartTxFlag | uartRxFlag;
    flags[`SRC_BOD] = brownoutFlag;
    flags[`SRC_SBUS] = serialBusAttention;
    flags[`SRC_KEY] = keypadFlag;
    flags[`SRC_CMP2] = comparator2Flag;
    flags[`SRC_WDOG] = watchdogOverflowFlag;
    flags[`SRC_ADC] = converterDoneFlag;
    flags[`SRC_CMP1] = comparator1Flag;
    flags[`SRC_BTMO] = busTimeoutFlag;
  end

  // enable and priority bits live at scattered positions of the two registers
  always_comb begin
    enables = {enableRegB[`ENB_BTMO_BIT], enableRegB[5:4], enableRegA[`ENA_WDOG_BIT],
               enableRegB[2:0], enableRegA[5:0]};
    prioLow = {prioLowRegB[7], prioLowRegB[5:4], prioLowRegA[6], prioLowRegB[2:0],
               prioLowRegA[5:0]};
    prioHigh = {prioHighRegB[7], prioHighRegB[5:4], prioHighRegA[6], prioHighRegB[2:0],
                prioHighRegA[5:0]};
    gated = flags & enables & {NS{enableRegA[`ENA_GLOBAL_BIT]}};
  end

  prio_arbiter #(
    .NUM_SRC(NS)
  ) arb (
    .request(gated),
    .prioHigh(prioHigh),
    .prioLow(prioLow),
    .found(found),
    .winner(winner),
    .winLevel(winLevel)
  );

  // current running level is the highest set in-service bit
  always_comb begin
    curValid = |st.inService;
    curLevel = 2'h0;
    for (int l = 0; l < `INTC_NUM_LVL; l++) begin
      if (st.inService[l]) begin
        curLevel = 2'(l);
      end
    end
  end

  // -------------------------------------------------------------------
  // request and nesting
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.mcCount = sampleStrobe ? '0 : st.mcCount + 3'h1;
    if (vectorAck && st.pend) begin
      next_st.inService[st.pendLevel] = 1'b1;
      next_st.pend = 1'b0;
    end else if (serviceReturn && curValid) begin
      // pop only the most recent level, the one beneath resumes
      next_st.inService[curLevel] = 1'b0;
    end
    if (!(vectorAck && st.pend)) begin
      // a request must strictly beat the running level; level 3 is never preempted
      if (found && (!curValid || (winLevel > curLevel))) begin
        next_st.pend = 1'b1;
        next_st.pendSrc = winner;
        next_st.pendLevel = winLevel;
        next_st.vector = VECTORS[winner*16 +: 16];
      end else begin
        next_st.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign irqRequest = st.pend;
  assign irqVector = st.vector;
  assign activeLevel = curLevel;
  assign serviceActive = curValid;
  // wake needs global allow as well as the source's own enable
  assign wakeup = powerDown ? |(gated & WAKE) : |gated;
endmodule : four_level_interrupt_controller

// ===== intc_cfg.svh
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

// -------------------------------------------------------------------
// sizes and timing
// -------------------------------------------------------------------
`define INTC_NUM_SRC 13
`define INTC_NUM_LVL 4
`define INTC_MC_CLOCKS 6
`define INTC_MC_CNT_W 3

// -------------------------------------------------------------------
// source index = bit in the packed request/enable/priority vectors
// -------------------------------------------------------------------
`define SRC_EXT0 0
`define SRC_TMR0 1
`define SRC_EXT1 2
`define SRC_TMR1 3
`define SRC_UART 4
`define SRC_BOD 5
`define SRC_SBUS 6
`define SRC_KEY 7
`define SRC_CMP2 8
`define SRC_WDOG 9
`define SRC_ADC 10
`define SRC_CMP1 11
`define SRC_BTMO 12

// enable_reg_a bit positions
`define ENA_GLOBAL_BIT 7
`define ENA_WDOG_BIT 6
// enable_reg_b bit positions
`define ENB_BTMO_BIT 7

// arbitration ranking, index 0 is highest
`define RANK_LIST {4'hC, 4'h4, 4'h8, 4'h3, 4'hB, 4'h7, 4'h2, 4'hA, 4'h6, 4'h1, 4'h9, 4'h5, 4'h0}

// wakeup-capable sources
`define WAKE_MASK 13'h0FA5

`define VEC_TABLE {16'h0073, 16'h0063, 16'h005B, 16'h0053, 16'h0043, 16'h003B, 16'h0033, \
  16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003}

`define INTC_RESET_REG 8'h00
`endif

// ===== intc_pkg.sv
package intc_pkg;
  typedef enum logic [1:0] {
    LVL0,
    LVL1,
    LVL2,
    LVL3
  } level_t;
  typedef logic [12:0] src_vec_t;
endpackage : intc_pkg

// ===== ext_irq_input.sv
`timescale 1ns/10ps
`include "intc_cfg.svh"
module ext_irq_input (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and sampling
  input wire logic extIrqPin,
  input wire logic sampleStrobe,
  input wire logic triggerType,
  // core acknowledge
  input wire logic vectorAck,
  // flag
  output logic requestFlag
);
  typedef struct packed {
    logic lastSample;
    logic flag;
  } state_t;

  state_t st;
  state_t next_st;

  always_comb begin
    next_st = st;
    if (sampleStrobe) begin
      next_st.lastSample = extIrqPin;
    end
    if (!triggerType) begin
      // level: flag tracks the latest sample of the pin
      next_st.flag = sampleStrobe ? ~extIrqPin : st.flag;
    end else begin
      if (vectorAck) begin
        next_st.flag = 1'b0;
      end
      // set wins over the acknowledge clear
      if (sampleStrobe && st.lastSample && !extIrqPin) begin
        next_st.flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{lastSample: 1'b1, flag: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign requestFlag = st.flag;
endmodule : ext_irq_input

// ===== prio_arbiter.sv
`timescale 1ns/10ps
`include "intc_cfg.svh"
module prio_arbiter #(
  parameter int NUM_SRC = `INTC_NUM_SRC
) (
  // candidates
  input wire logic [NUM_SRC-1:0] request,
  input wire logic [NUM_SRC-1:0] prioHigh,
  input wire logic [NUM_SRC-1:0] prioLow,
  // result
  output logic found,
  output logic [3:0] winner,
  output logic [1:0] winLevel
);
  localparam logic [51:0] RANK = `RANK_LIST;

  always_comb begin
    logic [3:0] idx;
    logic [1:0] lvl;
    idx = 4'h0;
    lvl = 2'h0;
    found = 1'b0;
    winner = 4'h0;
    winLevel = 2'h0;
    // walk ranking low to high priority; later equal-or-better level overrides
    for (int r = NUM_SRC - 1; r >= 0; r--) begin
      idx = RANK[r*4 +: 4];
      lvl = {prioHigh[idx], prioLow[idx]};
      if (request[idx] && (!found || lvl >= winLevel)) begin
        found = 1'b1;
        winner = idx;
        winLevel = lvl;
      end
    end
  end
endmodule : prio_arbiter

// ===== four_level_interrupt_controller_props.sv
`timescale 1ns/10ps
module four_level_interrupt_controller_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs
  input wire logic [7:0] enableRegA,
  input wire logic ext0TriggerType,
  input wire logic ext0IrqPin_n,
  input wire logic vectorAck,
  input wire logic serviceReturn,
  // outputs
  input wire logic irqRequest,
  input wire logic [15:0] irqVector,
  input wire logic [1:0] activeLevel,
  input wire logic serviceActive,
  input wire logic ext0RequestFlag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----
  // properties
  // ----
  ack_pushes_a: assert property (vectorAck && irqRequest |=> serviceActive && !irqRequest)
    else $error("ack not taken into service");
  preempt_higher_a: assert property (
    vectorAck && irqRequest && serviceActive |=> activeLevel > $past(activeLevel))
    else $error("preemption without higher level");
  top_level_a: assert property (activeLevel == 2'h3 |-> !irqRequest)
    else $error("request during top level");
  global_mask_a: assert property (!enableRegA[7] ##1 !enableRegA[7] |-> !irqRequest)
    else $error("request while globally masked");
  vec_align_a: assert property (
    irqRequest |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h0073 && irqVector != 16'h004B)
    else $error("vector off table");
  // eight cycles always spans one pin sample
  level_follow_a: assert property (
    (!ext0TriggerType && !ext0IrqPin_n) [*8] |=> ext0RequestFlag)
    else $error("level flag not set");
  level_release_a: assert property (
    (!ext0TriggerType && ext0IrqPin_n) [*8] |=> !ext0RequestFlag)
    else $error("level flag not cleared");
  ret_lowers_a: assert property (
    serviceReturn && !vectorAck |=> activeLevel <= $past(activeLevel))
    else $error("return raised level");
  cover property (vectorAck && serviceActive);
  cover property (activeLevel == 2'h3);
  cover property (serviceReturn && activeLevel == 2'h2);
endmodule : four_level_interrupt_controller_props

bind four_level_interrupt_controller four_level_interrupt_controller_props props_u (.clk,
  .rst_n, .enableRegA, .ext0TriggerType, .ext0IrqPin_n, .vectorAck, .serviceReturn,
  .irqRequest, .irqVector, .activeLevel, .serviceActive, .ext0RequestFlag);

// ===== core_model.sv
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller side
  input wire logic irqRequest,
  input wire logic [15:0] irqVector,
  output logic vectorAck,
  // bench side
  input wire logic ackEn,
  output logic [15:0] takenVector,
  output int ackCount
);
  // vector captured at the edge that takes it, so a late retarget is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorAck <= 1'b0;
      takenVector <= 16'h0000;
      ackCount <= 0;
    end else if (vectorAck) begin
      vectorAck <= 1'b0;
      takenVector <= irqVector;
      ackCount <= ackCount + 1;
    end else begin
      vectorAck <= irqRequest && ackEn;
    end
  end
endmodule : core_model

// ===== four_level_interrupt_controller_tb.sv
`timescale 1ns/10ps
module four_level_interrupt_controller_tb;
  localparam logic [15:0] VEC [13] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h0053, 16'h005B, 16'h0063, 16'h0073};
  localparam int RANK [13] = '{0, 5, 9, 1, 6, 10, 2, 7, 11, 3, 8, 4, 12};
  logic clk, rst_n, ga, pd, t1, ret, ackEn, vectorAck, irqRequest, serviceActive, wakeup;
  logic f0, f1, rx;
  logic [1:0] pn, activeLevel;
  logic [12:0] fl, en, ph, pl;
  logic [15:0] enM, phM, plM, irqVector, takenVector;
  int ackCount, k;
  int bad_count = 0;
  int num_checks = 0;
  function automatic logic [15:0] mp(input logic [12:0] m);
    return {m[12], 1'b0, m[11:10], 1'b0, m[8:6], 1'b0, m[9], m[5:0]};
  endfunction : mp
  assign enM = mp(en);
  assign phM = mp(ph);
  assign plM = mp(pl);
  four_level_interrupt_controller dut_u (
    .clk(clk), .rst_n(rst_n), .enableRegA({ga, enM[6:0]}), .enableRegB(enM[15:8]),
    .prioLowRegA(plM[7:0]), .prioHighRegA(phM[7:0]), .prioLowRegB(plM[15:8]),
    .prioHighRegB(phM[15:8]), .ext0TriggerType(1'b0), .ext1TriggerType(t1),
    .ext0IrqPin_n(pn[0]), .ext1IrqPin_n(pn[1]), .timer0OverflowFlag(fl[1]),
    .timer1OverflowFlag(fl[3]), .uartTxFlag(fl[4]), .uartRxFlag(rx), .brownoutFlag(fl[5]),
    .serialBusAttention(fl[6]), .keypadFlag(fl[7]), .comparator2Flag(fl[8]),
    .watchdogOverflowFlag(fl[9]), .converterDoneFlag(fl[10]), .comparator1Flag(fl[11]),
    .busTimeoutFlag(fl[12]), .vectorAck(vectorAck), .serviceReturn(ret), .powerDown(pd),
    .irqRequest(irqRequest), .irqVector(irqVector), .activeLevel(activeLevel),
    .serviceActive(serviceActive), .wakeup(wakeup), .ext0RequestFlag(f0),
    .ext1RequestFlag(f1));
  core_model core_u (.clk(clk), .rst_n(rst_n), .irqRequest(irqRequest), .irqVector(irqVector),
    .vectorAck(vectorAck), .ackEn(ackEn), .takenVector(takenVector), .ackCount(ackCount));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ext pins mirror bits 0 and 2, active low
  task automatic setF(input logic [12:0] m);
    fl = m;
    pn = {~m[2], ~m[0]};
  endtask : setF
  task automatic take(input logic [15:0] exp);
    k = ackCount;
    for (int i = 0; i < 200 && ackCount == k; i++) @(negedge clk);
    // a vector that never came must not pass on a stale capture
    chk(16'(ackCount), 16'(k + 1));
    chk(takenVector, exp);
  endtask : take
  task automatic retire();
    ret = 1'b1;
    @(negedge clk);
    ret = 1'b0;
    @(negedge clk);
  endtask : retire
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ----
  // run
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    {ga, pd, t1, ret, ackEn, rst_n, rx} = 7'h0;
    {fl, en, ph, pl} = 52'h0;
    pn = 2'h3;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk(irqRequest, 1'b0);
    ackEn = 1'b1;
    en = 13'h1FFF;
    setF(13'h0002);
    repeat (10) @(negedge clk);
    chk(irqRequest, 1'b0);
    ga = 1'b1;
    take(16'h000B);
    setF(13'h0000);
    retire();
    for (int i = 0; i < 13; i++) begin
      en = 13'h0001 << i;
      setF(en);
      take(VEC[i]);
      setF(13'h0000);
      repeat (8) @(negedge clk);
      retire();
    end
    // receive half of the serial source shares the transmit vector
    en = 13'h0010;
    rx = 1'b1;
    take(16'h0023);
    rx = 1'b0;
    retire();
    // hold the core off until slow level pins are sampled
    ackEn = 1'b0;
    en = 13'h1FFF;
    setF(en);
    repeat (8) @(negedge clk);
    ackEn = 1'b1;
    for (int i = 0; i < 13; i++) begin
      take(VEC[RANK[i]]);
      setF(fl & ~(13'h0001 << RANK[i]));
      repeat (8) @(negedge clk);
      retire();
    end
    en = 13'h0001;
    setF(en);
    take(16'h0003);
    retire();
    take(16'h0003);
    chk(f0, 1'b1);
    setF(13'h0000);
    repeat (8) @(negedge clk);
    retire();
    en = 13'h003A;
    ph = 13'h0032;
    pl = 13'h002A;
    setF(13'h0018);
    take(16'h0023);
    setF(13'h0028);
    take(16'h002B);
    chk(activeLevel, 2'h3);
    setF(13'h000A);
    repeat (20) @(negedge clk);
    chk(16'(ackCount), 16'(k + 1));
    retire();
    take(16'h000B);
    setF(13'h0008);
    retire();
    chk(activeLevel, 2'h2);
    repeat (20) @(negedge clk);
    chk(irqRequest, 1'b0);
    retire();
    take(16'h001B);
    setF(13'h0000);
    retire();
    chk(serviceActive, 1'b0);
    t1 = 1'b1;
    ackEn = 1'b0;
    en = 13'h0004;
    repeat (14) @(negedge clk);
    chk(f1, 1'b0);
    pn[1] = 1'b0;
    repeat (14) @(negedge clk);
    pn[1] = 1'b1;
    repeat (14) @(negedge clk);
    chk(f1, 1'b1);
    ackEn = 1'b1;
    take(16'h0013);
    chk(f1, 1'b0);
    retire();
    ackEn = 1'b0;
    pd = 1'b1;
    en = 13'h0083;
    setF(13'h0002);
    @(negedge clk);
    chk(wakeup, 1'b0);
    setF(13'h0082);
    @(negedge clk);
    chk(wakeup, 1'b1);
    setF(13'h0001);
    repeat (8) @(negedge clk);
    chk(wakeup, 1'b1);
    summarize();
  end
endmodule : four_level_interrupt_controller_tb
